// ---- core/sfe_pkg.sv ----
// Shared constants for the serial memory front end: opcodes, status layout,
// guard ranges, timing and the host register map.
// Assumes a 40 MHz core clock on both ends.
package sfe_pkg;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PROGRAM      = 8'h02;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_WRITE_ARM    = 8'h06;
  localparam logic [7:0] OP_QUICK_READ   = 8'h0B;
  localparam logic [7:0] OP_PAGE_ERASE   = 8'h42;
  localparam logic [7:0] OP_FULL_ERASE_A = 8'h60;
  localparam logic [7:0] OP_FULL_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_SLEEP        = 8'hB9;
  localparam logic [7:0] OP_DEEP_SLEEP   = 8'h79;
  localparam logic [7:0] OP_WAKE         = 8'hAB;

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int BIT_BUSY        = 0;
  localparam int BIT_WRITE_ARM   = 1;
  localparam int BIT_GUARD_LO    = 2;
  localparam int BIT_GUARD_HI    = 3;
  localparam int BIT_LOW_STANDBY = 5;
  localparam int BIT_AUTO_SLEEP  = 6;
  localparam int BIT_LOCK        = 7;
  localparam logic [7:0] STATUS_NV_RESET = 8'h00;

  // ----------------------------------------
  // Block guard ranges and page geometry
  // ----------------------------------------
  localparam logic [15:0] GUARD_QUARTER_BASE = 16'h3000;
  localparam logic [15:0] GUARD_HALF_BASE    = 16'h2000;
  localparam int PAGE_BYTES  = 32;
  localparam int ADDR_BYTES  = 2;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int PROG_TIME_NS    = 1_000_000;
  localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int SCK_HALF_NS     = 100;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Host register map
  // ----------------------------------------
  localparam logic [3:0] REG_TX_BYTE = 4'h0;
  localparam logic [3:0] REG_RX_BYTE = 4'h4;
  localparam logic [3:0] REG_STATUS  = 4'h8;
  localparam logic [3:0] REG_GUARD   = 4'hC;
  localparam int TX_LAST_BIT = 8;

  typedef enum logic [2:0] {
    PWR_ACTIVE,
    PWR_STANDBY,
    PWR_LOW_STANDBY,
    PWR_SLEEP,
    PWR_DEEP_SLEEP
  } sfe_power_type;

endpackage : sfe_pkg

// ---- core/sfe_spi_if.sv ----
// Four-wire serial link plus the write guard pin between host and memory.
// The data-out wire idles high when the memory does not drive it.
`timescale 1ns/1ps
interface sfe_spi_if;
  logic serial_clk;
  logic chip_sel_n;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_n;
  logic write_guard_n;
  logic serial_out_line;

  assign serial_out_line = serial_out_oe_n ? 1'b1 : serial_out;

  modport device (
    input  serial_clk,
    input  chip_sel_n,
    input  serial_in,
    input  write_guard_n,
    output serial_out,
    output serial_out_oe_n
  );

  modport host (
    output serial_clk,
    output chip_sel_n,
    output serial_in,
    output write_guard_n,
    input  serial_out_line
  );
endinterface : sfe_spi_if

// ---- core/sfe_mem_dev.sv ----
// Serial memory device end: command decode, status register, protection.
// Assumes link pins are asynchronous to core_clk and the link clock is far slower.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module sfe_mem_dev
  import sfe_pkg::*;
#(
  parameter int ADDR_W      = 13,
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  // Link
  sfe_spi_if.device          spi,
  // User side
  output sfe_power_type      power_state,
  output logic [7:0]         status_view
);

  localparam int DEPTH = 1 << ADDR_W;

  typedef enum {
    ST_OP, ST_ADDR, ST_DUMMY, ST_RDATA, ST_SRDATA, ST_SRW, ST_WDATA, ST_DONE, ST_IGN
  } sfe_dev_state_type;

  // ----------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------
  logic [1:0] sck_s, cs_s, din_s, wg_s;
  logic       sck_prev_q, cs_prev_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sck_s      <= 2'h0;
      cs_s       <= 2'h3;
      din_s      <= 2'h0;
      wg_s       <= 2'h0;
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else if (clk_en) begin
      sck_s      <= {sck_s[0], spi.serial_clk};
      cs_s       <= {cs_s[0], spi.chip_sel_n};
      din_s      <= {din_s[0], spi.serial_in};
      wg_s       <= {wg_s[0], spi.write_guard_n};
      sck_prev_q <= sck_s[1];
      cs_prev_q  <= cs_s[1];
    end
  end

  logic cs_act, cs_end, sck_rise, sck_fall;
  // Edges count only while selected, so the idle level of either mode is harmless
  assign cs_act   = ~cs_s[1];
  assign cs_end   = cs_s[1] & ~cs_prev_q;
  assign sck_rise = cs_act & sck_s[1] & ~sck_prev_q;
  assign sck_fall = cs_act & ~sck_s[1] & sck_prev_q;

  // ----------------------------------------
  // Byte shifter
  // ----------------------------------------
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic       byte_done;
  logic [7:0] rx_byte;

  always_ff @(posedge core_clk) begin
    if (sys_rst || (clk_en && !cs_act)) begin
      bit_q <= 3'h0;
      sh_q  <= 8'h00;
    end else if (clk_en && sck_rise) begin
      sh_q  <= {sh_q[6:0], din_s[1]};
      bit_q <= bit_q + 3'h1;
    end
  end

  assign byte_done = sck_rise & (bit_q == 3'h7);
  assign rx_byte   = {sh_q[6:0], din_s[1]};

  // ----------------------------------------
  // Status register and array
  // ----------------------------------------
  logic [7:0]  mem [DEPTH];
  logic        lock_q, asleep_en_q, lowsb_q, wel_q, sleep_q, deep_q;
  logic [1:0]  guard_q;
  logic [31:0] busy_cnt_q;
  logic        busy;
  logic [7:0]  status;

  assign busy   = busy_cnt_q != 32'h0000_0000;
  assign status = {lock_q, asleep_en_q, lowsb_q, 1'b0, guard_q, wel_q, busy};
  assign status_view = status;

  function automatic logic guarded(input logic [1:0] g, input logic [15:0] a);
    case (g)
      2'h1:    guarded = a >= GUARD_QUARTER_BASE;
      2'h2:    guarded = a >= GUARD_HALF_BASE;
      2'h3:    guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction : guarded

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  sfe_dev_state_type state_q;
  logic [7:0]  cmd_q, tx_q, sdata_q;
  logic [15:0] addr_q;
  logic        acnt_q;
  logic [5:0]  wcnt_q;
  logic [15:0] addr_next;

  assign addr_next = {{(16 - ADDR_W){1'b0}}, addr_q[ADDR_W-1:0] + ADDR_W'(1)};

  always_ff @(posedge core_clk) begin
    if (sys_rst || (clk_en && !cs_act)) begin
      state_q <= ST_OP;
      cmd_q   <= 8'h00;
      tx_q    <= 8'h00;
      sdata_q <= 8'h00;
      addr_q  <= 16'h0000;
      acnt_q  <= 1'b0;
      wcnt_q  <= 6'h00;
    end else if (clk_en && byte_done) begin
      case (state_q)
        ST_OP: begin
          cmd_q <= rx_byte;
          if (deep_q || (sleep_q && rx_byte != OP_WAKE)) begin
            state_q <= ST_IGN;
          end else begin
            case (rx_byte)
              OP_READ, OP_QUICK_READ, OP_PROGRAM, OP_PAGE_ERASE: state_q <= ST_ADDR;
              OP_STATUS_READ: begin
                tx_q    <= status;
                state_q <= ST_SRDATA;
              end
              OP_STATUS_WRITE: state_q <= ST_SRW;
              OP_WRITE_DISARM, OP_WRITE_ARM, OP_FULL_ERASE_A, OP_FULL_ERASE_B,
              OP_SLEEP, OP_DEEP_SLEEP, OP_WAKE: state_q <= ST_DONE;
              default: state_q <= ST_IGN;
            endcase
          end
        end
        ST_ADDR: begin
          addr_q <= {addr_q[7:0], rx_byte};
          acnt_q <= 1'b1;
          if (acnt_q) begin
            case (cmd_q)
              OP_READ: begin
                tx_q    <= mem[{addr_q[ADDR_W-8-1:0], rx_byte}];
                addr_q  <= {{(16 - ADDR_W){1'b0}}, {addr_q[ADDR_W-8-1:0], rx_byte} + ADDR_W'(1)};
                state_q <= ST_RDATA;
              end
              OP_QUICK_READ: state_q <= ST_DUMMY;
              OP_PROGRAM:    state_q <= ST_WDATA;
              default:       state_q <= ST_DONE;
            endcase
          end
        end
        ST_DUMMY: begin
          tx_q    <= mem[addr_q[ADDR_W-1:0]];
          addr_q  <= addr_next;
          state_q <= ST_RDATA;
        end
        ST_RDATA: begin
          tx_q   <= mem[addr_q[ADDR_W-1:0]];
          addr_q <= addr_next;
        end
        ST_SRDATA: tx_q <= status;
        ST_SRW: begin
          sdata_q <= rx_byte;
          state_q <= ST_DONE;
        end
        ST_WDATA: begin
          if (wcnt_q != 6'(PAGE_BYTES)) begin
            wcnt_q <= wcnt_q + 6'h01;
          end
        end
        default: state_q <= state_q;
      endcase
    end
  end

  // ----------------------------------------
  // Page buffer
  // ----------------------------------------
  logic [7:0]            page_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pvld_q;
  logic [4:0]            pidx;

  // Bytes past the page end wrap within the page rather than spilling over; from the 33rd data byte on, each rewrites the first byte's slot
  assign pidx = addr_q[4:0] + wcnt_q[4:0];

  always_ff @(posedge core_clk) begin
    if (sys_rst || (clk_en && !cs_act)) begin
      pvld_q <= '0;
    end else if (clk_en && byte_done && state_q == ST_WDATA) begin
      page_q[pidx] <= rx_byte;
      pvld_q[pidx] <= 1'b1;
    end
  end

  // ----------------------------------------
  // Execution at deselect
  // ----------------------------------------
  logic exec, write_ok, status_open;
  logic [15:0] page_base;

  // A partial byte or a missing byte leaves the command unexecuted
  assign exec = cs_end && bit_q == 3'h0 &&
                (state_q == ST_DONE || (state_q == ST_WDATA && wcnt_q != 6'h00));
  assign write_ok    = wel_q & ~busy;
  assign status_open = ~lock_q | wg_s[1];
  assign page_base   = {addr_q[15:5], 5'h00};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {lock_q, asleep_en_q, lowsb_q} <= {STATUS_NV_RESET[BIT_LOCK], STATUS_NV_RESET[BIT_AUTO_SLEEP],
                                          STATUS_NV_RESET[BIT_LOW_STANDBY]};
      guard_q    <= {STATUS_NV_RESET[BIT_GUARD_HI], STATUS_NV_RESET[BIT_GUARD_LO]};
      wel_q      <= 1'b0;
      sleep_q    <= 1'b0;
      deep_q     <= 1'b0;
      busy_cnt_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (busy) begin
        busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
      end
      if (exec) begin
        case (cmd_q)
          OP_WRITE_ARM:    wel_q <= 1'b1;
          OP_WRITE_DISARM: wel_q <= 1'b0;
          OP_STATUS_WRITE: begin
            if (write_ok && status_open) begin
              lock_q      <= sdata_q[BIT_LOCK];
              asleep_en_q <= sdata_q[BIT_AUTO_SLEEP];
              lowsb_q     <= sdata_q[BIT_LOW_STANDBY];
              guard_q     <= {sdata_q[BIT_GUARD_HI], sdata_q[BIT_GUARD_LO]};
              wel_q       <= 1'b0;
              busy_cnt_q  <= 32'(PROG_CYCLES);
            end
          end
          OP_PROGRAM, OP_PAGE_ERASE, OP_FULL_ERASE_A, OP_FULL_ERASE_B: begin
            if (write_ok) begin
              wel_q      <= 1'b0;
              busy_cnt_q <= 32'(PROG_CYCLES);
            end
          end
          OP_SLEEP: begin
            sleep_q <= 1'b1;
            wel_q   <= 1'b0;
          end
          OP_DEEP_SLEEP: deep_q  <= 1'b1;
          OP_WAKE:       sleep_q <= 1'b0;
          default:       wel_q   <= wel_q;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clk_en && exec && write_ok) begin
      case (cmd_q)
        OP_PROGRAM: begin
          for (int i = 0; i < PAGE_BYTES; i++) begin
            if (pvld_q[i] && !guarded(guard_q, page_base | 16'(i))) begin
              mem[ADDR_W'(page_base | 16'(i))] <= page_q[i];
            end
          end
        end
        OP_PAGE_ERASE: begin
          for (int i = 0; i < PAGE_BYTES; i++) begin
            if (!guarded(guard_q, page_base | 16'(i))) begin
              mem[ADDR_W'(page_base | 16'(i))] <= ERASED_BYTE;
            end
          end
        end
        OP_FULL_ERASE_A, OP_FULL_ERASE_B: begin
          for (int i = 0; i < DEPTH; i++) begin
            if (!guarded(guard_q, 16'(i))) begin
              mem[i] <= ERASED_BYTE;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  logic so_q, so_oe_n_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst || (clk_en && !cs_act)) begin
      so_q      <= 1'b0;
      so_oe_n_q <= 1'b1;
    end else if (clk_en && sck_fall && (state_q == ST_RDATA || state_q == ST_SRDATA)) begin
      so_q      <= tx_q[3'h7 - bit_q];
      so_oe_n_q <= 1'b0;
    end
  end

  assign spi.serial_out      = so_q;
  assign spi.serial_out_oe_n = so_oe_n_q;

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  always_comb begin
    if (deep_q) begin
      power_state = PWR_DEEP_SLEEP;
    end else if (cs_act || busy) begin
      power_state = PWR_ACTIVE;
    end else if (sleep_q || asleep_en_q) begin
      power_state = PWR_SLEEP;
    end else if (lowsb_q) begin
      power_state = PWR_LOW_STANDBY;
    end else begin
      power_state = PWR_STANDBY;
    end
  end

endmodule : sfe_mem_dev

// ---- core/sfe_spi_host.sv ----
// Host end: shifts one byte per register write over the link in mode 0.
// Assumes software waits for the busy bit to clear between bytes.
`timescale 1ns/1ps
module sfe_spi_host
  import sfe_pkg::*;
#(
  parameter int HALF_CYCLES = SCK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Link
  sfe_spi_if.host          spi
);

  typedef enum {HS_IDLE, HS_LEAD, HS_HIGH, HS_LOW, HS_TRAIL, HS_GAP} sfe_host_state_type;

  // ----------------------------------------
  // Data-out synchroniser
  // ----------------------------------------
  logic [1:0] din_s;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      din_s <= 2'h3;
    end else if (clk_en) begin
      din_s <= {din_s[0], spi.serial_out_line};
    end
  end

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  sfe_host_state_type st_q;
  logic [7:0]  tx_q, rx_sh_q, rx_q;
  logic [2:0]  bits_q;
  logic [15:0] cnt_q;
  logic        last_q, sck_q, cs_n_q, mosi_q, guard_n_q;
  logic        start, tick;

  assign start = reg_wr && reg_addr == REG_TX_BYTE && st_q == HS_IDLE;
  assign tick  = cnt_q == 16'h0000;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q    <= HS_IDLE;
      tx_q    <= 8'h00;
      rx_sh_q <= 8'h00;
      rx_q    <= 8'h00;
      bits_q  <= 3'h0;
      cnt_q   <= 16'h0000;
      last_q  <= 1'b0;
      sck_q   <= 1'b0;
      cs_n_q  <= 1'b1;
      mosi_q  <= 1'b0;
    end else if (clk_en) begin
      if (!tick) begin
        cnt_q <= cnt_q - 16'h0001;
      end
      case (st_q)
        HS_IDLE: begin
          if (start) begin
            tx_q   <= reg_wdata[7:0];
            last_q <= reg_wdata[TX_LAST_BIT];
            mosi_q <= reg_wdata[7];
            cs_n_q <= 1'b0;
            bits_q <= 3'h0;
            cnt_q  <= 16'(HALF_CYCLES - 1);
            st_q   <= HS_LEAD;
          end
        end
        HS_LEAD, HS_LOW: begin
          if (tick) begin
            sck_q <= 1'b1;
            cnt_q <= 16'(HALF_CYCLES - 1);
            st_q  <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (tick) begin
            // Sampled late in the high phase to absorb the device's sync delay
            rx_sh_q <= {rx_sh_q[6:0], din_s[1]};
            sck_q   <= 1'b0;
            bits_q  <= bits_q + 3'h1;
            cnt_q   <= 16'(HALF_CYCLES - 1);
            tx_q    <= {tx_q[6:0], 1'b0};
            mosi_q  <= tx_q[6];
            if (bits_q == 3'h7) begin
              rx_q <= {rx_sh_q[6:0], din_s[1]};
              st_q <= last_q ? HS_TRAIL : HS_IDLE;
            end else begin
              st_q <= HS_LOW;
            end
          end
        end
        HS_TRAIL: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            cnt_q  <= 16'(HALF_CYCLES - 1);
            st_q   <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (tick) begin
            st_q <= HS_IDLE;
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      guard_n_q <= 1'b1;
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == REG_GUARD) begin
        guard_n_q <= reg_wdata[0];
      end
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          REG_RX_BYTE: reg_rdata <= {24'h00_0000, rx_q};
          REG_STATUS:  reg_rdata <= {30'h0000_0000, ~cs_n_q, st_q != HS_IDLE};
          REG_GUARD:   reg_rdata <= {31'h0000_0000, guard_n_q};
          default:     reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign spi.serial_clk    = sck_q;
  assign spi.chip_sel_n    = cs_n_q;
  assign spi.serial_in     = mosi_q;
  assign spi.write_guard_n = guard_n_q;

endmodule : sfe_spi_host

// ---- tb/sfe_link_properties.sv ----
// Link checker: clock phases, framing and output release between the two ends.
// Takes the interface signals as plain inputs; tb_top instantiates it beside the link.
`timescale 1ns/1ps
module sfe_link_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link
  input wire logic serial_clk,
  input wire logic chip_sel_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  // Link clock rises in this frame; saturates so long reads never wrap the count
  logic       sck_q;
  logic [7:0] rise_q;
  always_ff @(posedge core_clk) begin
    sck_q <= serial_clk;
    if (sys_rst || chip_sel_n) begin
      rise_q <= 8'h00;
    end else if (serial_clk && !sck_q && rise_q != 8'hFF) begin
      rise_q <= rise_q + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_low4;
    (!serial_clk) [*4];
  endsequence
  sequence s_high4;
    serial_clk [*4];
  endsequence
  property p_idle_low;
    chip_sel_n |-> !serial_clk;
  endproperty
  property p_setup;
    $fell(chip_sel_n) |-> s_low4;
  endproperty
  property p_high;
    $rose(serial_clk) |-> s_high4;
  endproperty
  property p_in_stable;
    serial_clk |-> $stable(serial_in);
  endproperty
  property p_out_launch;
    !serial_out_oe_n && $changed(serial_out) |-> !serial_clk;
  endproperty
  property p_release;
    $rose(chip_sel_n) |-> ##[1:4] serial_out_oe_n;
  endproperty
  property p_bytes;
    $rose(chip_sel_n) |-> rise_q[2:0] == 3'h0;
  endproperty
  property p_drive_late;
    $fell(serial_out_oe_n) |-> !chip_sel_n && rise_q >= 8'h08;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("link clock high while deselected");
  a_setup: assert property (p_setup) else $error("link clock rose too soon after select");
  a_high: assert property (p_high) else $error("short high phase");
  a_in_stable: assert property (p_in_stable) else $error("data in moved while clock high");
  a_out_launch: assert property (p_out_launch) else $error("data out moved while clock high");
  a_release: assert property (p_release) else $error("data out not released");
  a_bytes: assert property (p_bytes) else $error("frame not whole bytes");
  a_drive_late: assert property (p_drive_late) else $error("data out driven before opcode");
endmodule : sfe_link_properties

// ---- tb/tb_top.sv ----
// Testbench: drives the host register port; host and memory ends meet over the link.
// Assumes the package and the link interface are compiled first.
`timescale 1ns/1ps
module tb_top
  import sfe_pkg::*;
();
  logic          core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]    reg_addr = 4'h0;
  logic [31:0]   reg_wdata = 32'h0000_0000, reg_rdata;
  logic [7:0]    status_view, rx_b;
  sfe_power_type power_state;
  int            n_mismatch = 0, tests_run = 0;
  always #12.5 core_clk = ~core_clk;
  sfe_spi_if spi ();
  // Busy shortened, yet longer than three frames so writes can land inside it
  sfe_mem_dev #(.PROG_CYCLES(800)) sfe_mem_dev_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .spi(spi), .power_state(power_state), .status_view(status_view));
  sfe_spi_host sfe_spi_host_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spi(spi));
  sfe_link_properties sfe_link_properties_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .serial_clk(spi.serial_clk), .chip_sel_n(spi.chip_sel_n), .serial_in(spi.serial_in),
    .serial_out(spi.serial_out), .serial_out_oe_n(spi.serial_out_oe_n));
  task conclude;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task hang;
    n_mismatch++;
    conclude;
  endtask : hang
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task rg(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rg
  // One byte per register write; software polls busy because the host never stalls the bus
  task tx(input logic [7:0] b, input logic last);
    logic [31:0] q;
    rg(1'b1, REG_TX_BYTE, 32'({last, b}), q);
    for (int i = 0; i < 300; i++) begin
      rg(1'b0, REG_STATUS, 32'h0000_0000, q);
      if (q[0] === 1'b0) break;
      if (i == 299) hang;
    end
    rg(1'b0, REG_RX_BYTE, 32'h0000_0000, q);
    rx_b = q[7:0];
  endtask : tx
  task cmd(input logic [7:0] q[$]);
    foreach (q[i]) tx(q[i], i == q.size() - 1);
  endtask : cmd
  task idle;
    for (int i = 0; i < 2000; i++) begin
      @(posedge core_clk);
      if (status_view[BIT_BUSY] === 1'b0) break;
      if (i == 1999) hang;
    end
  endtask : idle
  task sw(input logic [7:0] v);
    cmd('{OP_WRITE_ARM});
    cmd('{OP_STATUS_WRITE, v});
    idle;
  endtask : sw
  task sc_reset;
    logic [31:0] q;
    chk(status_view, STATUS_NV_RESET);
    chk(power_state, PWR_STANDBY);
    rg(1'b0, REG_GUARD, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
    rg(1'b0, 4'h2, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    cmd('{OP_WRITE_ARM});
    chk(status_view, 8'h02);
    cmd('{OP_STATUS_READ, 8'h00, 8'h00});
    chk(rx_b, 8'h02);
    cmd('{OP_WRITE_DISARM});
    chk(status_view, 8'h00);
  endtask : sc_reset
  task sc_array;
    cmd('{OP_WRITE_ARM});
    cmd('{OP_FULL_ERASE_B});
    chk(status_view[BIT_BUSY], 1'b1);
    idle;
    cmd('{OP_READ, 8'h00, 8'h00, 8'h00});
    chk(rx_b, ERASED_BYTE);
    cmd('{OP_PROGRAM, 8'h00, 8'h00, 8'hAA});
    cmd('{OP_READ, 8'h00, 8'h00, 8'h00});
    chk(rx_b, ERASED_BYTE);
    cmd('{OP_WRITE_ARM});
    cmd('{OP_PROGRAM, 8'h00, 8'h00, 8'h12, 8'h34});
    idle;
    cmd('{OP_READ, 8'h00, 8'h00, 8'h00, 8'h00});
    chk(rx_b, 8'h34);
    cmd('{OP_QUICK_READ, 8'h00, 8'h00, 8'h00, 8'h00});
    chk(rx_b, 8'h12);
    cmd('{OP_READ, 8'h1F, 8'hFF, 8'h00, 8'h00});
    chk(rx_b, 8'h12);
    cmd('{OP_WRITE_ARM});
    cmd('{OP_PAGE_ERASE, 8'h00, 8'h00});
    idle;
    cmd('{OP_READ, 8'h00, 8'h01, 8'h00});
    chk(rx_b, ERASED_BYTE);
    cmd('{OP_WRITE_ARM});
    cmd('{OP_PROGRAM, 8'h00, 8'h00});
    chk(status_view, 8'h02);
    cmd('{OP_WRITE_DISARM});
  endtask : sc_array
  task sc_guard;
    logic [31:0] q;
    sw(8'h14);
    chk(status_view, 8'h04);
    cmd('{OP_WRITE_ARM});
    cmd('{OP_PROGRAM, 8'h30, 8'h00, 8'h55});
    idle;
    cmd('{OP_WRITE_ARM});
    cmd('{OP_PROGRAM, 8'h2F, 8'hFF, 8'h66});
    idle;
    cmd('{OP_READ, 8'h30, 8'h00, 8'h00});
    chk(rx_b, ERASED_BYTE);
    cmd('{OP_READ, 8'h2F, 8'hFF, 8'h00});
    chk(rx_b, 8'h66);
    rg(1'b1, REG_GUARD, 32'h0000_0000, q);
    sw(8'h80);
    chk(status_view, 8'h80);
    sw(8'h00);
    chk(status_view, 8'h82);
    rg(1'b1, REG_GUARD, 32'h0000_0001, q);
    sw(8'h00);
    chk(status_view, 8'h00);
  endtask : sc_guard
  task sc_busy;
    cmd('{OP_WRITE_ARM});
    cmd('{OP_PROGRAM, 8'h00, 8'h08, 8'h5A});
    cmd('{OP_WRITE_ARM});
    cmd('{OP_STATUS_WRITE, 8'h0C});
    cmd('{OP_STATUS_READ, 8'h00});
    chk(rx_b, 8'h03);
    idle;
    chk(status_view, 8'h02);
    cmd('{OP_FULL_ERASE_A});
    idle;
    cmd('{OP_READ, 8'h00, 8'h08, 8'h00});
    chk(rx_b, ERASED_BYTE);
  endtask : sc_busy
  task sc_power;
    sw(8'h20);
    chk(power_state, PWR_LOW_STANDBY);
    sw(8'h40);
    chk(power_state, PWR_SLEEP);
    sw(8'h00);
    cmd('{OP_WRITE_ARM});
    cmd('{OP_SLEEP});
    cmd('{OP_WRITE_ARM});
    chk(status_view, 8'h00);
    cmd('{OP_WAKE});
    chk(power_state, PWR_STANDBY);
    cmd('{OP_DEEP_SLEEP});
    cmd('{OP_WAKE});
    chk(power_state, PWR_DEEP_SLEEP);
  endtask : sc_power
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    sc_reset;
    sc_array;
    sc_guard;
    sc_busy;
    sc_power;
    conclude;
  end
endmodule : tb_top
